// *** common/hall_pkg.sv ***
package hall_pkg;
   // Register word offsets (byte addresses on the 8-bit address port)
   localparam logic [7:0] OFS_MODE = 8'h00;
   localparam logic [7:0] OFS_MODEN = 8'h04;
   localparam logic [7:0] OFS_PERIOD = 8'h08;
   localparam logic [7:0] OFS_CMP1 = 8'h0C;
   localparam logic [7:0] OFS_CMP2 = 8'h10;
   localparam logic [7:0] OFS_CAPTURE = 8'h14;
   localparam logic [7:0] OFS_TIMER = 8'h18;
   localparam logic [7:0] OFS_FLAGS = 8'h1C;
   localparam logic [7:0] OFS_FLAG_SET = 8'h20;
   localparam logic [7:0] OFS_FLAG_CLR = 8'h24;
   localparam logic [7:0] OFS_IEN = 8'h28;
   localparam logic [7:0] OFS_PASSIVE = 8'h2C;
   localparam logic [7:0] OFS_HP_SHADOW = 8'h30;
   localparam logic [7:0] OFS_HP_ACTIVE = 8'h34;
   localparam logic [7:0] OFS_MCM_CTRL = 8'h38;
   localparam logic [7:0] OFS_HALL_DELAY = 8'h3C;

   // Mode register fields
   localparam int MSEL0_LSB = 0;
   localparam int MSEL1_LSB = 4;
   localparam int MSEL2_LSB = 8;
   localparam int MSEL_W = 4;
   localparam logic [3:0] MSEL_BLDC = 4'h8;
   localparam int RUN_BIT = 12;
   localparam int HALT_EN_BIT = 13;
   localparam int MCM_EN_BIT = 14;

   // Multi-channel control fields
   localparam int SW_CHE_BIT = 0;
   localparam int SWITCHING_ENABLE_BIT = 1;

   // Flag bit positions
   localparam int F_CHE = 0;
   localparam int F_WHE = 1;
   localparam int F_STR = 2;
   localparam int F_TIMEOUT = 3;
   localparam int F_HALT = 4;
   localparam int NUM_EVT_FLAGS = 4;

   // Hall and pattern shadow fields
   localparam int HP_REQ_BIT = 15;
   localparam int CUR_MSB = 13;
   localparam int CUR_LSB = 11;
   localparam int EXP_MSB = 10;
   localparam int EXP_LSB = 8;
   localparam int PAT_REQ_BIT = 7;
   localparam int PAT_MSB = 5;

   localparam logic [15:0] RESET_WORD = 16'h0000;
endpackage

// *** design/hall_commutation_control.sv ***
// Functional notes
// R1 - Software selects brushless mode by writing 1000 to all three mode fields.
// R2 - In brushless mode channel 0 captures; channels 1 and 2 compare.
// R3 - Correct Hall event loads compare 1, compare 2 and period actives.
// R4 - Correct Hall event captures timer count then clears timer to zero.
// R5 - Brushless mode suppresses the normal shadow transfer of passive levels.
// R6 - Write to a shadowed register with timer stopped updates shadow and main.
// R7 - Channel 1 match triggers output pattern transfer when switching enabled.
// R8 - Channel 2 match is a time-out event with interrupt.
// R9 - Software clears all timer modulation enables in brushless mode.
// R10 - Correct Hall flag set on expected match or by software set bit.
// R11 - Enabled correct Hall set event raises an interrupt request.
// R12 - Correct Hall flag clears only by writing 1 to its clear bit.
// R13 - Wrong Hall flag handled like correct Hall flag, set by wrong event.
// R14 - Pattern transfer flag set on each pattern shadow transfer.
// R15 - Every set event raises enabled interrupt, even if flag already set.
// R16 - Output halt set by wrong Hall event if enabled, or by software.
// R17 - While output halt set the active output pattern is held cleared.
// R18 - Software clears halt then requests both pattern transfers to restart.
// R19 - Hall request bit 15 copies written shadows to active; reads zero.
// R20 - Correct Hall event copies current and expected shadows to active.
// R21 - Pattern request bit 7 copies written pattern to active; reads zero.
// R22 - Pattern shadow moves to active only under configured triggers.
// R23 - Delayed sample: expected gives correct, current nothing, else wrong.
`timescale 1ns/1ps
`default_nettype none

module hall_commutation_control #(
   parameter int TIMER_W = 16,
   parameter int DELAY_W = 8
) (
   input wire logic SYS_CLK,
   input wire logic SYS_RST,
   input wire logic [7:0] ADDR,
   input wire logic [15:0] WR_DATA,
   input wire logic WR_EN,
   input wire logic RD_EN,
   output logic [15:0] RD_DATA,
   input wire logic [2:0] HALL_IN,
   output logic [5:0] OUT_PATTERN,
   output logic [5:0] PASSIVE_LEVEL,
   output logic INT_REQ
);

   generate
      if (TIMER_W < 8 || TIMER_W > 16 || DELAY_W < 2 || DELAY_W > 16) begin : g_bad_width
         $error("Unsupported width parameter");
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Registers and decode

   logic [15:0] mode;
   logic [5:0] moden;
   logic [TIMER_W-1:0] period_sh, period_act;
   logic [TIMER_W-1:0] cmp1_sh, cmp1_act, cmp2_sh, cmp2_act;
   logic [TIMER_W-1:0] capture, timer;
   logic [5:0] passive_sh, passive_main;
   logic [4:0] flags;
   logic [3:0] interrupt_enable_register;
   logic [2:0] cur_sh, exp_sh, cur_act, exp_act;
   logic [5:0] pat_sh, pat_act;
   logic [1:0] mcm_ctrl;
   logic [DELAY_W-1:0] hall_delay, delay_cnt;
   logic [2:0] hall_prev;

   logic bldc, run, stopped;
   logic w_mode, w_moden, w_period, w_cmp1, w_cmp2, w_passive;
   logic w_fset, w_fclr, w_ien, w_hp, w_mcm, w_delay;
   logic hp_req, pat_req;
   logic eval, correct_hall_flag, wrong_hall_flag;
   logic period_match, ch1_match, ch2_match;
   logic normal_st, pattern_shadow_transfer, halt_set;
   logic [3:0] evt_hw, evt_sw, evt_any;

   assign w_mode = WR_EN && ADDR == hall_pkg::OFS_MODE;
   assign w_moden = WR_EN && ADDR == hall_pkg::OFS_MODEN;
   assign w_period = WR_EN && ADDR == hall_pkg::OFS_PERIOD;
   assign w_cmp1 = WR_EN && ADDR == hall_pkg::OFS_CMP1;
   assign w_cmp2 = WR_EN && ADDR == hall_pkg::OFS_CMP2;
   assign w_passive = WR_EN && ADDR == hall_pkg::OFS_PASSIVE;
   assign w_fset = WR_EN && ADDR == hall_pkg::OFS_FLAG_SET;
   assign w_fclr = WR_EN && ADDR == hall_pkg::OFS_FLAG_CLR;
   assign w_ien = WR_EN && ADDR == hall_pkg::OFS_IEN;
   assign w_hp = WR_EN && ADDR == hall_pkg::OFS_HP_SHADOW;
   assign w_mcm = WR_EN && ADDR == hall_pkg::OFS_MCM_CTRL;
   assign w_delay = WR_EN && ADDR == hall_pkg::OFS_HALL_DELAY;

   assign hp_req = w_hp && WR_DATA[hall_pkg::HP_REQ_BIT];
   assign pat_req = w_hp && WR_DATA[hall_pkg::PAT_REQ_BIT];

   // Brushless mode only when all three channels carry the brushless code 1000
   assign bldc =
      mode[hall_pkg::MSEL0_LSB +: hall_pkg::MSEL_W] == hall_pkg::MSEL_BLDC &&
      mode[hall_pkg::MSEL1_LSB +: hall_pkg::MSEL_W] == hall_pkg::MSEL_BLDC &&
      mode[hall_pkg::MSEL2_LSB +: hall_pkg::MSEL_W] == hall_pkg::MSEL_BLDC; // R1
   assign run = mode[hall_pkg::RUN_BIT];
   assign stopped = !run;

   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         mode <= hall_pkg::RESET_WORD;
         moden <= '0;
         interrupt_enable_register <= '0;
         mcm_ctrl <= '0;
         hall_delay <= '0;
      end else begin
         if (w_mode) begin
            mode <= WR_DATA;
         end
         // Kept for software only; brushless mode expects all zero
         if (w_moden) begin
            moden <= WR_DATA[5:0]; // R9
         end
         if (w_ien) begin
            interrupt_enable_register <= WR_DATA[3:0];
         end
         if (w_mcm) begin
            mcm_ctrl <= WR_DATA[1:0];
         end
         if (w_delay) begin
            hall_delay <= WR_DATA[DELAY_W-1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Hall sampling and compare

   assign eval = delay_cnt == DELAY_W'(1);
   assign correct_hall_flag = eval && HALL_IN == exp_act; // R23
   assign wrong_hall_flag = eval && HALL_IN != exp_act && HALL_IN != cur_act; // R23

   // A change restarts the delay, so bouncing inputs are seen only once
   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         hall_prev <= '0;
         delay_cnt <= '0;
      end else begin
         hall_prev <= HALL_IN;
         if (HALL_IN != hall_prev) begin
            delay_cnt <= (hall_delay == '0) ? DELAY_W'(1) : hall_delay;
         end else if (delay_cnt != '0) begin
            delay_cnt <= delay_cnt - DELAY_W'(1);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Primary timer, capture and compare

   assign period_match = run && timer == period_act;
   assign ch1_match = run && bldc && timer == cmp1_act; // R2
   assign ch2_match = run && bldc && timer == cmp2_act; // R2 R8
   assign normal_st = period_match && !bldc; // R5

   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         timer <= '0;
         capture <= '0;
      end else begin
         if (bldc && correct_hall_flag) begin
            capture <= timer; // R4
            timer <= '0; // R4
         end else if (stopped) begin
            timer <= timer;
         end else if (period_match) begin
            timer <= '0;
         end else begin
            timer <= timer + TIMER_W'(1);
         end
      end
   end

   // Stopped-timer writes reach the main copy directly
   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         period_sh <= '1;
         period_act <= '1;
         cmp1_sh <= '0;
         cmp1_act <= '0;
         cmp2_sh <= '0;
         cmp2_act <= '0;
      end else begin
         if (w_period) begin
            period_sh <= WR_DATA[TIMER_W-1:0];
         end
         if (w_cmp1) begin
            cmp1_sh <= WR_DATA[TIMER_W-1:0];
         end
         if (w_cmp2) begin
            cmp2_sh <= WR_DATA[TIMER_W-1:0];
         end
         if (w_period && stopped) begin
            period_act <= WR_DATA[TIMER_W-1:0]; // R6
         end else if ((bldc && correct_hall_flag) || normal_st) begin
            period_act <= period_sh; // R3
         end
         if (w_cmp1 && stopped) begin
            cmp1_act <= WR_DATA[TIMER_W-1:0]; // R6
         end else if ((bldc && correct_hall_flag) || normal_st) begin
            cmp1_act <= cmp1_sh; // R3
         end
         if (w_cmp2 && stopped) begin
            cmp2_act <= WR_DATA[TIMER_W-1:0]; // R6
         end else if ((bldc && correct_hall_flag) || normal_st) begin
            cmp2_act <= cmp2_sh; // R3
         end
      end
   end

   // Passive levels move on the normal transfer or on a stopped-timer write; there is no normal transfer in brushless mode
   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         passive_sh <= '0;
         passive_main <= '0;
      end else begin
         if (w_passive) begin
            passive_sh <= WR_DATA[5:0];
         end
         if (w_passive && stopped) begin
            passive_main <= WR_DATA[5:0]; // R6
         end else if (normal_st) begin
            passive_main <= passive_sh; // R5
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Hall and output patterns

   assign pattern_shadow_transfer = mode[hall_pkg::MCM_EN_BIT] &&
      ((mcm_ctrl[hall_pkg::SW_CHE_BIT] && correct_hall_flag) ||
       (mcm_ctrl[hall_pkg::SWITCHING_ENABLE_BIT] && ch1_match)); // R7 R22

   // Software request wins over a same-cycle correct Hall event
   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         cur_sh <= '0;
         exp_sh <= '0;
         pat_sh <= '0;
         cur_act <= '0;
         exp_act <= '0;
      end else begin
         if (w_hp) begin
            cur_sh <= WR_DATA[hall_pkg::CUR_MSB:hall_pkg::CUR_LSB];
            exp_sh <= WR_DATA[hall_pkg::EXP_MSB:hall_pkg::EXP_LSB];
            pat_sh <= WR_DATA[hall_pkg::PAT_MSB:0];
         end
         if (hp_req) begin
            cur_act <= WR_DATA[hall_pkg::CUR_MSB:hall_pkg::CUR_LSB]; // R19
            exp_act <= WR_DATA[hall_pkg::EXP_MSB:hall_pkg::EXP_LSB]; // R19
         end else if (correct_hall_flag) begin
            cur_act <= cur_sh; // R20
            exp_act <= exp_sh; // R20
         end
      end
   end

   // Halt overrides every load so a stray transfer cannot re-arm outputs
   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         pat_act <= '0;
      end else if (flags[hall_pkg::F_HALT]) begin
         pat_act <= '0; // R17
      end else if (pat_req) begin
         pat_act <= WR_DATA[hall_pkg::PAT_MSB:0]; // R21 R18
      end else if (pattern_shadow_transfer) begin
         pat_act <= pat_sh; // R22
      end
   end

   assign OUT_PATTERN = pat_act;
   assign PASSIVE_LEVEL = passive_main;

   ////////////////////////////////////////////////////////////////////////
   // Flags and interrupt request

   assign evt_hw[hall_pkg::F_CHE] = correct_hall_flag; // R10
   assign evt_hw[hall_pkg::F_WHE] = wrong_hall_flag; // R13
   assign evt_hw[hall_pkg::F_STR] = pattern_shadow_transfer; // R14
   assign evt_hw[hall_pkg::F_TIMEOUT] = ch2_match; // R8
   assign evt_sw = w_fset ? WR_DATA[3:0] : 4'h0;
   assign evt_any = evt_hw | evt_sw;
   assign halt_set = (wrong_hall_flag && mode[hall_pkg::HALT_EN_BIT]) ||
      (w_fset && WR_DATA[hall_pkg::F_HALT]); // R16

   // Set wins over a clear written in the same cycle
   genvar gi;
   generate
      for (gi = 0; gi < hall_pkg::NUM_EVT_FLAGS; gi++) begin : g_flag
         always_ff @(posedge SYS_CLK) begin
            if (SYS_RST) begin
               flags[gi] <= 1'b0;
            end else if (evt_any[gi]) begin
               flags[gi] <= 1'b1; // R10 R13 R14
            end else if (w_fclr && WR_DATA[gi]) begin
               flags[gi] <= 1'b0; // R12
            end
         end
      end
   endgenerate

   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         flags[hall_pkg::F_HALT] <= 1'b0;
      end else if (halt_set) begin
         flags[hall_pkg::F_HALT] <= 1'b1; // R16
      end else if (w_fclr && WR_DATA[hall_pkg::F_HALT]) begin
         flags[hall_pkg::F_HALT] <= 1'b0; // R18
      end
   end

   // Fires on the set event itself, regardless of the flag's old value
   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         INT_REQ <= 1'b0;
      end else begin
         INT_REQ <= |(evt_any & interrupt_enable_register); // R11 R15
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read port

   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST || !RD_EN) begin
         RD_DATA <= '0;
      end else begin
         case (ADDR)
            hall_pkg::OFS_MODE: RD_DATA <= mode;
            hall_pkg::OFS_MODEN: RD_DATA <= {10'h000, moden};
            hall_pkg::OFS_PERIOD: RD_DATA <= 16'(period_act);
            hall_pkg::OFS_CMP1: RD_DATA <= 16'(cmp1_act);
            hall_pkg::OFS_CMP2: RD_DATA <= 16'(cmp2_act);
            hall_pkg::OFS_CAPTURE: RD_DATA <= 16'(capture);
            hall_pkg::OFS_TIMER: RD_DATA <= 16'(timer);
            hall_pkg::OFS_FLAGS: RD_DATA <= {11'h000, flags};
            hall_pkg::OFS_IEN: RD_DATA <= {12'h000, interrupt_enable_register};
            hall_pkg::OFS_PASSIVE: RD_DATA <= {10'h000, passive_sh};
            // Request bits read as zero
            hall_pkg::OFS_HP_SHADOW:
               RD_DATA <= {2'h0, cur_sh, exp_sh, 2'h0, pat_sh}; // R19 R21
            hall_pkg::OFS_HP_ACTIVE:
               RD_DATA <= {2'h0, cur_act, exp_act, 2'h0, pat_act};
            hall_pkg::OFS_MCM_CTRL: RD_DATA <= {14'h0000, mcm_ctrl};
            hall_pkg::OFS_HALL_DELAY: RD_DATA <= 16'(hall_delay);
            default: RD_DATA <= '0;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (SYS_RST);

   a_capture_on_che: assert property ( // R4
      bldc && correct_hall_flag |=> capture == $past(timer) && timer == '0)
      else $error("Capture or timer clear missed on correct Hall event");

   a_compare_transfer: assert property ( // R3
      bldc && correct_hall_flag && !(w_cmp1 && stopped) |=> cmp1_act == $past(cmp1_sh))
      else $error("Compare 1 not loaded on correct Hall event");

   a_passive_frozen: assert property ( // R5
      bldc && run |=> $stable(passive_main))
      else $error("Passive levels moved in brushless mode");

   a_stopped_write: assert property ( // R6
      w_passive && stopped |=> passive_main == $past(WR_DATA[5:0]))
      else $error("Stopped write did not reach main passive levels");

   a_che_irq: assert property ( // R11
      correct_hall_flag && interrupt_enable_register[hall_pkg::F_CHE] |=> INT_REQ && flags[hall_pkg::F_CHE])
      else $error("Correct Hall event gave no flag or interrupt");

   a_flag_clear: assert property ( // R12
      flags[hall_pkg::F_CHE] && !evt_any[hall_pkg::F_CHE] &&
      !(w_fclr && WR_DATA[hall_pkg::F_CHE]) |=> flags[hall_pkg::F_CHE])
      else $error("Correct Hall flag cleared without clear write");

   a_wrong_hall: assert property ( // R23
      eval && HALL_IN != exp_act && HALL_IN != cur_act
      |=> flags[hall_pkg::F_WHE])
      else $error("Wrong Hall pattern did not set wrong flag");

   a_halt_pattern: assert property ( // R17
      flags[hall_pkg::F_HALT] |=> pat_act == '0)
      else $error("Output pattern not held cleared during halt");

   a_hall_request: assert property ( // R19
      hp_req |=> cur_act == $past(WR_DATA[hall_pkg::CUR_MSB:hall_pkg::CUR_LSB])
         && exp_act == $past(WR_DATA[hall_pkg::EXP_MSB:hall_pkg::EXP_LSB]))
      else $error("Hall pattern request not applied");

   a_timeout_flag: assert property ( // R8
      ch2_match |=> flags[hall_pkg::F_TIMEOUT])
      else $error("Channel 2 match did not set time-out flag");

   a_halt_on_wrong: assert property ( // R16
      wrong_hall_flag && mode[hall_pkg::HALT_EN_BIT] |=> flags[hall_pkg::F_HALT])
      else $error("Wrong Hall event did not halt outputs");

endmodule // hall_commutation_control

`default_nettype wire

// *** tb/hall_sensor_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module hall_sensor_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic [2:0] target,
   input wire logic bounce,
   output logic [2:0] hall
);
   logic [2:0] settled;
   logic bouncing;

   // A bounce flashes the inverse for one cycle, inside the sampling delay
   always_ff @(posedge clk) begin
      if (rst) begin
         settled <= 3'h0;
         hall <= 3'h0;
         bouncing <= 1'b0;
      end else if (target != settled) begin
         settled <= target;
         hall <= bounce ? ~target : target;
         bouncing <= bounce;
      end else if (bouncing) begin
         hall <= settled;
         bouncing <= 1'b0;
      end
   end
endmodule // hall_sensor_model

`default_nettype wire

// *** tb/hall_commutation_control_tb.sv ***
`timescale 1ns/1ps
`default_nettype none

module hall_commutation_control_tb;
   logic sys_clk;
   logic sys_rst;
   logic [7:0] addr;
   logic [15:0] wr_data;
   logic wr_en;
   logic rd_en;
   logic [15:0] rd_data;
   logic [2:0] hall_in;
   logic [2:0] target;
   logic bounce;
   logic [5:0] out_pattern;
   logic [5:0] passive_level;
   logic int_req;
   int n_errors = 0;
   int checks_done = 0;
   int irq_cnt = 0;
   int i0;
   logic [15:0] cap;
   logic [15:0] tmr;

   hall_commutation_control hall_commutation_control_inst (
      .SYS_CLK(sys_clk), .SYS_RST(sys_rst), .ADDR(addr), .WR_DATA(wr_data),
      .WR_EN(wr_en), .RD_EN(rd_en), .RD_DATA(rd_data), .HALL_IN(hall_in),
      .OUT_PATTERN(out_pattern), .PASSIVE_LEVEL(passive_level),
      .INT_REQ(int_req)
   );

   hall_sensor_model hall_sensor_model_inst (
      .clk(sys_clk), .rst(sys_rst), .target(target), .bounce(bounce),
      .hall(hall_in)
   );

   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end

   always @(posedge sys_clk) begin
      if (int_req === 1'b1) begin
         irq_cnt <= irq_cnt + 1;
      end
   end

   ////////////////////////////////////////////////////////////////////
   task report_and_stop;
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge sys_clk);
      wr_en <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task rchk(input logic [7:0] a, input logic [15:0] e, input logic [15:0] m);
      @(posedge sys_clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge sys_clk);
      rd_en <= 1'b0;
      @(negedge sys_clk);
      chk(rd_data & m, e);
   endtask

   task rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge sys_clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge sys_clk);
      rd_en <= 1'b0;
      @(negedge sys_clk);
      d = rd_data;
   endtask

   // Fixed wait covers the programmed delay of 4 plus a bounce restart
   task hall(input logic [2:0] p);
      @(posedge sys_clk);
      target <= p;
      repeat (14) @(posedge sys_clk);
   endtask

   task out_is(input logic [5:0] p);
      @(negedge sys_clk);
      chk({10'h000, out_pattern}, {10'h000, p});
   endtask

   ////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge sys_clk);
      n_errors++;
      report_and_stop;
   end

   initial begin
      sys_rst = 1'b1;
      addr = 8'h00;
      wr_data = 16'h0000;
      wr_en = 1'b0;
      rd_en = 1'b0;
      target = 3'h0;
      bounce = 1'b0;
      repeat (10) @(posedge sys_clk);
      sys_rst <= 1'b0;
      out_is(6'h00);
      rchk(hall_pkg::OFS_FLAGS, 16'h0000, 16'hFFFF);
      rchk(hall_pkg::OFS_PERIOD, 16'hFFFF, 16'hFFFF);
      rchk(8'hFC, 16'h0000, 16'hFFFF);
      wr(hall_pkg::OFS_MODE, 16'h0888);
      wr(hall_pkg::OFS_MODEN, 16'h0000);
      wr(hall_pkg::OFS_HALL_DELAY, 16'h0004);
      wr(hall_pkg::OFS_IEN, 16'h0007);
      wr(hall_pkg::OFS_MCM_CTRL, 16'h0001);
      wr(hall_pkg::OFS_PASSIVE, 16'h0015);
      out_is(6'h00);
      chk({10'h000, passive_level}, 16'h0015);
      wr(hall_pkg::OFS_CMP1, 16'h0011);
      rchk(hall_pkg::OFS_CMP1, 16'h0011, 16'hFFFF);
      wr(hall_pkg::OFS_HP_SHADOW, 16'h8B95);
      rchk(hall_pkg::OFS_HP_ACTIVE, 16'h0B15, 16'hFFFF);
      rchk(hall_pkg::OFS_HP_SHADOW, 16'h0B15, 16'hFFFF);
      out_is(6'h15);
      hall(3'h1);
      rchk(hall_pkg::OFS_FLAGS, 16'h0000, 16'h0017);
      // Timer running: writes now reach the shadow copies only
      wr(hall_pkg::OFS_MODE, 16'h7888);
      wr(hall_pkg::OFS_PERIOD, 16'h0100);
      wr(hall_pkg::OFS_CMP1, 16'h0030);
      wr(hall_pkg::OFS_CMP2, 16'h0080);
      wr(hall_pkg::OFS_PASSIVE, 16'h002A);
      rchk(hall_pkg::OFS_CMP1, 16'h0011, 16'hFFFF);
      rchk(hall_pkg::OFS_PERIOD, 16'hFFFF, 16'hFFFF);
      wr(hall_pkg::OFS_HP_SHADOW, 16'h1E2A);
      rchk(hall_pkg::OFS_HP_ACTIVE, 16'h0B15, 16'hFFFF);
      i0 = irq_cnt;
      bounce <= 1'b1;
      hall(3'h3);
      rd(hall_pkg::OFS_CAPTURE, cap);
      rd(hall_pkg::OFS_TIMER, tmr);
      chk({15'h0000, cap > 16'h0010 && tmr < 16'h0020}, 16'h0001);
      chk({15'h0000, irq_cnt != i0}, 16'h0001);
      rchk(hall_pkg::OFS_FLAGS, 16'h0005, 16'h0017);
      rchk(hall_pkg::OFS_HP_ACTIVE, 16'h1E2A, 16'hFFFF);
      rchk(hall_pkg::OFS_CMP1, 16'h0030, 16'hFFFF);
      rchk(hall_pkg::OFS_CMP2, 16'h0080, 16'hFFFF);
      rchk(hall_pkg::OFS_PERIOD, 16'h0100, 16'hFFFF);
      // Reset compare value 0 already raised a time-out at run start
      wr(hall_pkg::OFS_FLAG_CLR, 16'h0008);
      rchk(hall_pkg::OFS_FLAGS, 16'h0000, 16'h0008);
      repeat (300) @(posedge sys_clk);
      rchk(hall_pkg::OFS_FLAGS, 16'h0008, 16'h0008);
      chk({10'h000, passive_level}, 16'h0015);
      rchk(hall_pkg::OFS_PASSIVE, 16'h002A, 16'hFFFF);
      // Wrong transition with halt enabled
      bounce <= 1'b0;
      hall(3'h5);
      rchk(hall_pkg::OFS_FLAGS, 16'h0017, 16'h0017);
      out_is(6'h00);
      wr(hall_pkg::OFS_FLAG_CLR, 16'h0000);
      rchk(hall_pkg::OFS_FLAGS, 16'h0017, 16'h0017);
      wr(hall_pkg::OFS_FLAG_CLR, 16'h001F);
      wr(hall_pkg::OFS_FLAGS, 16'h001F);
      rchk(hall_pkg::OFS_FLAGS, 16'h0000, 16'h0017);
      wr(hall_pkg::OFS_HP_SHADOW, 16'h9EAA);
      out_is(6'h2A);
      wr(hall_pkg::OFS_HP_SHADOW, 16'h1E0C);
      repeat (300) @(posedge sys_clk);
      out_is(6'h2A);
      wr(hall_pkg::OFS_MCM_CTRL, 16'h0002);
      for (int i = 0; i < 300 && out_pattern !== 6'h0C; i++) begin
         @(posedge sys_clk);
      end
      out_is(6'h0C);
      rchk(hall_pkg::OFS_FLAGS, 16'h0004, 16'h0004);
      // Stop channel-1 transfers so only software sets pulse the request
      wr(hall_pkg::OFS_MCM_CTRL, 16'h0000);
      wr(hall_pkg::OFS_FLAG_CLR, 16'h001F);
      i0 = irq_cnt;
      wr(hall_pkg::OFS_FLAG_SET, 16'h0001);
      wr(hall_pkg::OFS_FLAG_SET, 16'h0001);
      repeat (3) @(posedge sys_clk);
      chk(16'(irq_cnt - i0), 16'h0002);
      rchk(hall_pkg::OFS_FLAGS, 16'h0001, 16'h0017);
      wr(hall_pkg::OFS_IEN, 16'h0000);
      i0 = irq_cnt;
      wr(hall_pkg::OFS_FLAG_SET, 16'h0002);
      repeat (3) @(posedge sys_clk);
      chk(16'(irq_cnt - i0), 16'h0000);
      rchk(hall_pkg::OFS_FLAGS, 16'h0003, 16'h0017);
      wr(hall_pkg::OFS_FLAG_SET, 16'h0010);
      // Pattern clears one cycle after the halt flag rises
      @(posedge sys_clk);
      out_is(6'h00);
      report_and_stop;
   end
endmodule // hall_commutation_control_tb

`default_nettype wire
